// File: bench/mass_frame_model.sv
/*
 Frame side model: one frame start, then a phy completion.
 Assumes the bench pulses go for one cycle with info held.
*/
module mass_frame_model (
	// Clock and request
	input  wire logic                  mclk,
	input  wire logic                  go,
	input  wire logic                  ok,
	input  wire mass_pkg::mass_frame_s info,
	// Frame events
	output mass_pkg::mass_frame_s      frame_info,
	output logic                       frame_start = 1'b0,
	output logic                       phy_done = 1'b0,
	output logic                       phy_ok = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	import mass_pkg::*;
	initial begin
		frame_info = '0;
		forever begin
			@(posedge mclk);
			if (go) begin
				{frame_start, frame_info} <= {1'b1, info};
				@(posedge mclk);
				// Stale fields inverted so no match by accident
				{frame_start, frame_info} <= {1'b0, ~info};
				@(posedge mclk);
				{phy_done, phy_ok} <= {1'b1, ok};
				@(posedge mclk);
				{phy_done, phy_ok} <= {1'b0, ~ok};
			end
		end
	end
endmodule : mass_frame_model

// File: bench/tb.sv
/*
 Bench of mass_support: register tasks, queued read checks.
 Assumes mass_frame_model drives the frame events.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mass_pkg::*;
	logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, go = 0, ok = 0, bv = 0, ba = 0, bh = 0;
	logic [7:0]   reg_addr = '0, si_d;
	logic [31:0]  reg_wdata = '0, r = '0, cfg, reg_rdata;
	logic [39:0]  note;
	logic [47:0]  grp, snd;
	logic [15:0]  seq;
	logic         irq, rx_enable, fs, pd, pok, sync_ind;
	logic [255:0] cmap, emap;
	mass_beacon_s bcn_adv;
	mass_frame_s  info = '0, fi;
	logic [39:0]  q[$];
	int errors = 0, total_checks = 0, inds = 0, cyc = 0, stp = 0;
	mass_support u_mass_support (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.bcn_rx_valid(bv), .bcn_rx_anchor_element(ba), .bcn_rx_hibernation_element(bh), .bcn_adv,
		.contention_bitmap(cmap), .superframe_start(r[0] & r[1]), .slot_start(r[0]), .slot_index(r[15:8]),
		.nbr_hard(r[2]), .nbr_soft(r[3]), .contention_slot(r[4]), .rx_enable, .frame_start(fs),
		.frame_info(fi), .phy_done(pd), .phy_ok(pok), .sync_ind);
	mass_frame_model u_mass_frame_model (.mclk, .go, .ok, .info, .frame_info(fi), .frame_start(fs),
		.phy_done(pd), .phy_ok(pok));
	initial forever #25 mclk = ~mclk;
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back({a, e});
		@(posedge mclk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic frame(input logic d, k);
		@(posedge mclk);
		{go, ok, info} <= {2'b11 & {1'b1, k}, r[0], d, grp, snd, seq};
		@(posedge mclk);
		go <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask : frame
	always @(posedge mclk) begin
		r <= $urandom;
		// Slot index the gate sampled at this edge
		si_d <= r[15:8];
		// Cycle count since reset release, for the frame start stamp
		if (rst_b) cyc <= cyc + 1;
		if (fs === 1'b1) stp <= cyc;
		rd_d <= reg_rd;
		if (sync_ind === 1'b1) inds++;
		if (rd_d) begin
			note = q.pop_front();
			chk($sformatf("reg %h", note[39:32]), reg_rdata, note[31:0]);
		end
	end
	initial begin
		#100us;
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(56124));
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		rd(OFF_RESULT, 32'h0);
		rd(OFF_IRQ_MASK, 32'h0);
		rd(8'hFC, 32'h0);
		wr(OFF_IRQ_MASK, 32'h1F);
		wr(OFF_CTRL, 32'h3);
		rd(OFF_CTRL, 32'h1);
		chk("anchor_capable", bcn_adv.anchor_capable, 1'b1);
		chk("irq", irq, 1'b1);
		@(posedge mclk);
		{bv, ba, bh} <= 3'b111;
		@(posedge mclk);
		{bv, ba, bh} <= 3'b000;
		repeat (2) @(negedge mclk);
		chk("anchor_element_on", bcn_adv.anchor_element_on, 1'b1);
		rd(OFF_IRQ_STAT, 32'h3);
		wr(OFF_IRQ_STAT, 32'h3);
		// Clear lands at the edge the task returns on
		@(negedge mclk);
		chk("irq", irq, 1'b0);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_RESULT, 32'h0);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_RESULT, 32'h1);
		cfg = $urandom & 32'hFF1C;
		for (int i = 0; i < 8; i++) begin
			emap[32*i +: 32] = $urandom;
			wr(OFF_MAP + 8'(4 * i), emap[32*i +: 32]);
		end
		for (int m = 0; m < 4; m++) begin
			wr(OFF_SLEEP_CFG, cfg | 32'(m));
			wr(OFF_CTRL, 32'h4);
			rd(OFF_RESULT, (m == 3) ? 32'h5 : 32'h1);
			@(negedge mclk);
			if (m < 2) chk("rx_enable", rx_enable, m ? emap[si_d] : 1'b1);
		end
		// Read back shows the staged word, the refused mode 3 included
		rd(OFF_SLEEP_CFG, cfg | 32'h3);
		chk("slot_limit", bcn_adv.contention_slot_limit, cfg[15:8]);
		chk("adv_on", bcn_adv.contention_adv_on, cfg[4]);
		for (int i = 0; i < 8; i++) chk("bitmap", cmap[32*i +: 32], emap[32*i +: 32]);
		grp = {16'($urandom), $urandom};
		snd = {16'($urandom), $urandom};
		seq = 16'($urandom);
		for (int g = 0; g < 2; g++) begin
			grp[MCAST_BIT] = g[0];
			wr(OFF_GROUP_LO, grp[31:0]);
			wr(OFF_GROUP_HI, {16'h0, grp[47:32]});
			wr(OFF_CTRL, 32'h8);
			rd(OFF_RESULT, g ? 32'h05 : 32'h25);
		end
		wr(OFF_IRQ_STAT, 32'h1F);
		frame(1'b1, 1'b0);
		frame(1'b0, 1'b1);
		rd(OFF_IRQ_STAT, 32'h0);
		frame(1'b1, 1'b1);
		rd(OFF_IRQ_STAT, 32'h10);
		rd(OFF_SEQ, 32'(seq));
		rd(OFF_SEND_LO, snd[31:0]);
		rd(OFF_SEND_HI, {16'h0, snd[47:32]});
		rd(OFF_GROUP_LO, grp[31:0]);
		rd(OFF_STAMP, 32'(stp));
		repeat (3) @(posedge mclk);
		chk("sync_pulses", 32'(inds), 32'h1);
		summarize();
	end
endmodule : tb

// File: design/mass_pkg.sv
/*
 Package of the anchor, sleep schedule and sync support block:
 register offsets, field positions, reset values, codes and carriers.
 Assumes a single 20 MHz clock and a management entity on the plain
 register port above, beacon, slot and frame events from the MAC below.
*/
// Behaviour
// RULE1: Anchor activation advertises capability in beacon
// RULE2: Active anchor adds element after hibernation heard
// RULE3: Received anchor element raises indication
// RULE4: Anchor start/stop returns success or failure
// RULE5: Schedule request defines receive slots
// RULE6: Accepted schedule updates slots and contention element
// RULE7: Every schedule request returns outcome code
// RULE8: Sync activation returns an outcome code
// RULE9: Indicate every matching data frame, tx or rx
// RULE10: Indication timed to frame start on medium
// RULE11: Indication carries group, sender, sequence count
// RULE12: Unsupported or non-multicast group reports unsupported
// RULE13: Indicate only after physical layer success
// RULE14: Manager picks always, schedule or load
// RULE15: Contention slot limit 0 to 255 per superframe
// RULE16: Bitmap holds one receive bit per slot
// RULE17: Receiver off in slots not selected
package mass_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int SLOTS   = 256;
	localparam int SLOT_W  = 8;
	localparam int MAP_WDS = 8;
	localparam int EUI_W   = 48;
	localparam int SEQ_W   = 16;
	localparam int N_EV    = 5;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_RESULT    = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h0C;
	localparam logic [7:0] OFF_SLEEP_CFG = 8'h10;
	localparam logic [7:0] OFF_GROUP_LO  = 8'h14;
	localparam logic [7:0] OFF_GROUP_HI  = 8'h18;
	localparam logic [7:0] OFF_SEND_LO   = 8'h1C;
	localparam logic [7:0] OFF_SEND_HI   = 8'h20;
	localparam logic [7:0] OFF_SEQ       = 8'h24;
	localparam logic [7:0] OFF_STAMP     = 8'h28;
	localparam logic [7:0] OFF_MAP       = 8'h40;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ANCHOR_REQ = 0;
	localparam int CTRL_ANCHOR_OP  = 1;
	localparam int CTRL_SLEEP_REQ  = 2;
	localparam int CTRL_SYNC_REQ   = 3;
	localparam int STAT_ANCHOR     = 0;
	localparam int STAT_ELEMENT    = 1;
	localparam int STAT_SYNC       = 2;
	localparam int SC_MODE_LSB     = 0;
	localparam int SC_HARD         = 2;
	localparam int SC_SOFT         = 3;
	localparam int SC_STAY         = 4;
	localparam int SC_LIMIT_LSB    = 8;
	localparam int MCAST_BIT       = 40;
	localparam int EV_ANCHOR_CONF  = 0;
	localparam int EV_ANCHOR_RX    = 1;
	localparam int EV_SLEEP_CONF   = 2;
	localparam int EV_SYNC_CONF    = 3;
	localparam int EV_SYNC_IND     = 4;

	// ----------------------------------------------------------------
	// Codes and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SLEEP_ALWAYS = 2'b00,
		SLEEP_SCHED  = 2'b01,
		SLEEP_LOAD   = 2'b10
	} mass_sleep_e;

	typedef enum logic [1:0] {
		OUTCOME_SUCCESS     = 2'b00,
		OUTCOME_FAILURE     = 2'b01,
		OUTCOME_UNSUPPORTED = 2'b10
	} mass_outcome_e;

	typedef struct packed {
		logic [7:0] contention_slot_limit;
		logic       stay_on_for_contention;
		logic       on_soft;
		logic       on_hard;
		logic [1:0] sleep_operation_select;
	} mass_sleep_cfg_s;

	typedef struct packed {
		logic             is_tx;
		logic             is_data;
		logic [EUI_W-1:0] destination_address_field;
		logic [EUI_W-1:0] sender_address;
		logic [SEQ_W-1:0] frame_sequence_count;
	} mass_frame_s;

	typedef struct packed {
		logic       anchor_capable;
		logic       anchor_element_on;
		logic       contention_adv_on;
		logic [7:0] contention_slot_limit;
	} mass_beacon_s;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam mass_sleep_cfg_s SLEEP_CFG_RST = '0;
	localparam logic [N_EV-1:0] IRQ_MASK_RST  = '0;

endpackage : mass_pkg

// File: design/mass_rx_gate.sv
/*
 Per-slot receiver gate for the sleep schedule.
 Assumes slot_index is stable through a slot and slot_start marks its
 first cycle; superframe_start coincides with the first slot start.
*/
module mass_rx_gate #(
	parameter int SLOTS  = 256,
	parameter int SLOT_W = 8
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_b,
	// Active schedule
	input  wire mass_pkg::mass_sleep_cfg_s cfg,
	input  wire logic [SLOTS-1:0]         slot_map,
	// Slot timing and neighbour usage
	input  wire logic                     superframe_start,
	input  wire logic                     slot_start,
	input  wire logic [SLOT_W-1:0]        slot_index,
	input  wire logic                     nbr_hard,
	input  wire logic                     nbr_soft,
	input  wire logic                     contention_slot,
	// Receiver control
	output logic                          rx_on
);
	import mass_pkg::*;

	logic [7:0] cont_used;
	logic       cont_grant;
	logic       want_cont;
	logic [7:0] used_base;
	logic       next_on;

	// Count restarts each superframe; limit 0 never grants
	assign used_base = superframe_start ? 8'h00 : cont_used;
	assign want_cont = cfg.stay_on_for_contention && contention_slot
		&& (used_base < cfg.contention_slot_limit);    // see RULE15

	// Grant latched per slot so the count cannot cut a slot short
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cont_used  <= 8'h00;
			cont_grant <= 1'b0;
		end else if (slot_start) begin
			cont_grant <= want_cont;
			cont_used  <= used_base + {7'h00, want_cont};  // see RULE15
		end else if (superframe_start) begin
			cont_used <= 8'h00;
		end
	end

	always_comb begin
		case (cfg.sleep_operation_select)
			SLEEP_ALWAYS: next_on = 1'b1;
			SLEEP_SCHED:  next_on = slot_map[slot_index];   // see RULE16
			SLEEP_LOAD:   next_on = (nbr_hard && cfg.on_hard)
				|| (nbr_soft && cfg.on_soft) || cont_grant;
			default:      next_on = 1'b1;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) rx_on <= 1'b1;
		else rx_on <= next_on;                             // see RULE17
	end

	property p_sched_gate;
		@(posedge mclk) disable iff (!rst_b)
		(cfg.sleep_operation_select == SLEEP_SCHED) |=> (rx_on == $past(slot_map[slot_index]));
	endproperty
	a_sched_gate: assert property (p_sched_gate) // see RULE17
		else $error("receiver gate does not follow slot bitmap");

endmodule : mass_rx_gate

// File: design/mass_support.sv
/*
 Anchor, sleep schedule and higher layer sync support of the MAC.
 Assumes the management entity drives the register port and the MAC
 core supplies beacon contents, slot timing and frame events.
*/
// The address-and-strobe port and the register offsets are this design's own decisions.
module mass_support #(
	parameter bit SYNC_SUPPORT = 1'b1,
	parameter int STAMP_W      = 32
) (
	// Clock and reset
	input  wire logic                            mclk,
	input  wire logic                            rst_b,
	// Register port
	input  wire logic [mass_pkg::ADDR_W-1:0]     reg_addr,
	input  wire logic [31:0]                     reg_wdata,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	output logic [31:0]                          reg_rdata,
	output logic                                 irq,
	// Beacon contents
	input  wire logic                            bcn_rx_valid,
	input  wire logic                            bcn_rx_anchor_element,
	input  wire logic                            bcn_rx_hibernation_element,
	output mass_pkg::mass_beacon_s               bcn_adv,
	output logic [mass_pkg::SLOTS-1:0]           contention_bitmap,
	// Slot timing
	input  wire logic                            superframe_start,
	input  wire logic                            slot_start,
	input  wire logic [mass_pkg::SLOT_W-1:0]     slot_index,
	input  wire logic                            nbr_hard,
	input  wire logic                            nbr_soft,
	input  wire logic                            contention_slot,
	output logic                                 rx_enable,
	// Frame events
	input  wire logic                            frame_start,
	input  wire mass_pkg::mass_frame_s           frame_info,
	input  wire logic                            phy_done,
	input  wire logic                            phy_ok,
	output logic                                 sync_ind
);
	import mass_pkg::*;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_map(input logic [ADDR_W-1:0] a);
		return (a >= OFF_MAP) && (a < OFF_MAP + 8'(4 * MAP_WDS)) && (a[1:0] == 2'b00);
	endfunction : is_map

	function automatic logic [2:0] map_word(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFF_MAP;
		return d[4:2];
	endfunction : map_word

	typedef enum logic {
		SYNC_IDLE  = 1'b0,
		SYNC_FRAME = 1'b1
	} mass_sync_e;

	logic                  ctrl_wr;
	logic                  anchor_req;
	logic                  sleep_req;
	logic                  sync_req;
	logic                  anchor_active;
	logic                  heard_hib;
	mass_outcome_e         res_anchor;
	mass_outcome_e         res_sleep;
	mass_outcome_e         res_sync;
	mass_sleep_cfg_s       sleep_stage;
	mass_sleep_cfg_s       sleep_cfg;
	logic [31:0]           stage_map [MAP_WDS];
	logic [SLOTS-1:0]      active_map;
	logic [EUI_W-1:0]      group_stage;
	logic [EUI_W-1:0]      registered_group_address;
	logic                  sync_active;
	logic                  group_ok;
	logic                  match;
	mass_sync_e            sync_state;
	logic [EUI_W-1:0]      cap_src;
	logic [SEQ_W-1:0]      cap_seq;
	logic [STAMP_W-1:0]    cap_stamp;
	logic [STAMP_W-1:0]    time_cnt;
	logic [EUI_W-1:0]      ind_sender;
	logic [SEQ_W-1:0]      ind_seq;
	logic [STAMP_W-1:0]    ind_stamp;
	logic                  ind_fire;
	logic [N_EV-1:0]       ev;
	logic [N_EV-1:0]       irq_stat;
	logic [N_EV-1:0]       irq_mask;
	logic [N_EV-1:0]       next_irq_stat;

	assign ctrl_wr    = reg_wr && (reg_addr == OFF_CTRL);
	assign anchor_req = ctrl_wr && reg_wdata[CTRL_ANCHOR_REQ];
	assign sleep_req  = ctrl_wr && reg_wdata[CTRL_SLEEP_REQ];
	assign sync_req   = ctrl_wr && reg_wdata[CTRL_SYNC_REQ];

	// ----------------------------------------------------------------
	// Staged parameters
	// ----------------------------------------------------------------
	// Request parameters are staged so a half-written schedule is never live
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sleep_stage <= SLEEP_CFG_RST;
			group_stage <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				OFF_SLEEP_CFG: sleep_stage <= mass_sleep_cfg_s'({reg_wdata[SC_LIMIT_LSB +: 8],
					reg_wdata[SC_STAY], reg_wdata[SC_SOFT], reg_wdata[SC_HARD],
					reg_wdata[SC_MODE_LSB +: 2]});
				OFF_GROUP_LO:  group_stage[31:0] <= reg_wdata;
				OFF_GROUP_HI:  group_stage[47:32] <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < MAP_WDS; i++) stage_map[i] <= 32'h0000_0000;
		end else if (reg_wr && is_map(reg_addr)) begin
			stage_map[map_word(reg_addr)] <= reg_wdata;     // see RULE16
		end
	end

	// ----------------------------------------------------------------
	// Hibernation anchor
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			anchor_active <= 1'b0;
			heard_hib     <= 1'b0;
			res_anchor    <= OUTCOME_SUCCESS;
		end else if (anchor_req) begin
			if (reg_wdata[CTRL_ANCHOR_OP]) begin
				anchor_active <= 1'b1;                       // see RULE1
				res_anchor    <= OUTCOME_SUCCESS;            // see RULE4
			end else if (anchor_active) begin
				anchor_active <= 1'b0;
				heard_hib     <= 1'b0;
				res_anchor    <= OUTCOME_SUCCESS;            // see RULE4
			end else begin
				// Stopping an anchor that is not active
				res_anchor <= OUTCOME_FAILURE;               // see RULE4
			end
		end else if (anchor_active && bcn_rx_valid && bcn_rx_hibernation_element) begin
			heard_hib <= 1'b1;                               // see RULE2
		end
	end

	// ----------------------------------------------------------------
	// Sleep schedule
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sleep_cfg  <= SLEEP_CFG_RST;
			active_map <= '0;
			res_sleep  <= OUTCOME_SUCCESS;
		end else if (sleep_req) begin
			// Code 11 names no sleep operation
			if (sleep_stage.sleep_operation_select == 2'b11) begin
				res_sleep <= OUTCOME_FAILURE;                // see RULE7
			end else begin
				sleep_cfg <= sleep_stage;                    // see RULE6
				for (int i = 0; i < MAP_WDS; i++)
					active_map[i*32 +: 32] <= stage_map[i];  // see RULE5
				res_sleep <= OUTCOME_SUCCESS;                // see RULE7
			end
		end
	end

	mass_rx_gate #(
		.SLOTS  (SLOTS),
		.SLOT_W (SLOT_W)
	) u_gate (
		.mclk             (mclk),
		.rst_b            (rst_b),
		.cfg              (sleep_cfg),
		.slot_map         (active_map),
		.superframe_start (superframe_start),
		.slot_start       (slot_start),
		.slot_index       (slot_index),
		.nbr_hard         (nbr_hard),
		.nbr_soft         (nbr_soft),
		.contention_slot  (contention_slot),
		.rx_on            (rx_enable)
	);

	// ----------------------------------------------------------------
	// Beacon advertisement
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bcn_adv           <= '0;
			contention_bitmap <= '0;
		end else begin
			bcn_adv.anchor_capable        <= anchor_active;              // see RULE1
			bcn_adv.anchor_element_on     <= anchor_active && heard_hib; // see RULE2
			bcn_adv.contention_adv_on     <= sleep_cfg.stay_on_for_contention; // see RULE6
			bcn_adv.contention_slot_limit <= sleep_cfg.contention_slot_limit;
			contention_bitmap             <= active_map;
		end
	end

	// ----------------------------------------------------------------
	// Higher layer sync
	// ----------------------------------------------------------------
	assign group_ok = SYNC_SUPPORT && group_stage[MCAST_BIT];
	assign match    = frame_start && sync_active && frame_info.is_data
		&& (frame_info.destination_address_field == registered_group_address); // see RULE9

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync_active              <= 1'b0;
			registered_group_address <= '0;
			res_sync                 <= OUTCOME_SUCCESS;
		end else if (sync_req) begin
			if (group_ok) begin
				sync_active              <= 1'b1;
				registered_group_address <= group_stage;
				res_sync                 <= OUTCOME_SUCCESS;     // see RULE8
			end else begin
				sync_active <= 1'b0;
				res_sync    <= OUTCOME_UNSUPPORTED;          // see RULE12
			end
		end
	end

	// Free-running time base for frame start stamps
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) time_cnt <= '0;
		else time_cnt <= time_cnt + STAMP_W'(1);
	end

	// A new matching start restarts the capture; a lost frame is dropped
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync_state <= SYNC_IDLE;
		end else begin
			unique case (sync_state)
				SYNC_IDLE:  if (match) sync_state <= SYNC_FRAME;
				SYNC_FRAME: if (frame_start && !match) sync_state <= SYNC_IDLE;
					else if (phy_done && !frame_start) sync_state <= SYNC_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cap_src   <= '0;
			cap_seq   <= '0;
			cap_stamp <= '0;
		end else if (match) begin
			cap_src   <= frame_info.sender_address;
			cap_seq   <= frame_info.frame_sequence_count;
			cap_stamp <= time_cnt;                           // see RULE10
		end
	end

	assign ind_fire = (sync_state == SYNC_FRAME) && phy_done && phy_ok && !frame_start; // see RULE13

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync_ind   <= 1'b0;
			ind_sender <= '0;
			ind_seq    <= '0;
			ind_stamp  <= '0;
		end else begin
			sync_ind <= ind_fire;                            // see RULE9
			if (ind_fire) begin
				ind_sender <= cap_src;                       // see RULE11
				ind_seq    <= cap_seq;                       // see RULE11
				ind_stamp  <= cap_stamp;                     // see RULE10
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_comb begin
		ev                 = '0;
		ev[EV_ANCHOR_CONF] = anchor_req;
		ev[EV_ANCHOR_RX]   = bcn_rx_valid && bcn_rx_anchor_element; // see RULE3
		ev[EV_SLEEP_CONF]  = sleep_req;
		ev[EV_SYNC_CONF]   = sync_req;
		ev[EV_SYNC_IND]    = ind_fire;
	end

	// Set wins over a same-cycle write-one clear
	always_comb begin
		next_irq_stat = irq_stat;
		if (reg_wr && reg_addr == OFF_IRQ_STAT)
			next_irq_stat = irq_stat & ~reg_wdata[N_EV-1:0];
		next_irq_stat = next_irq_stat | ev;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat <= '0;
			irq_mask <= IRQ_MASK_RST;
		end else begin
			irq_stat <= next_irq_stat;
			if (reg_wr && reg_addr == OFF_IRQ_MASK) irq_mask <= reg_wdata[N_EV-1:0];
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else if (is_map(reg_addr)) begin
			reg_rdata <= stage_map[map_word(reg_addr)];
		end else begin
			case (reg_addr)
				OFF_CTRL:      reg_rdata <= {29'h0, sync_active, anchor_active && heard_hib, anchor_active};
				OFF_RESULT:    reg_rdata <= {26'h0, res_sync, res_sleep, res_anchor};
				OFF_IRQ_STAT:  reg_rdata <= {27'h0, irq_stat};
				OFF_IRQ_MASK:  reg_rdata <= {27'h0, irq_mask};
				OFF_SLEEP_CFG: reg_rdata <= {16'h0, sleep_stage.contention_slot_limit, 3'h0,
					sleep_stage.stay_on_for_contention, sleep_stage.on_soft,
					sleep_stage.on_hard, sleep_stage.sleep_operation_select};
				OFF_GROUP_LO:  reg_rdata <= registered_group_address[31:0];
				OFF_GROUP_HI:  reg_rdata <= {16'h0, registered_group_address[47:32]};
				OFF_SEND_LO:   reg_rdata <= ind_sender[31:0];
				OFF_SEND_HI:   reg_rdata <= {16'h0, ind_sender[47:32]};
				OFF_SEQ:       reg_rdata <= 32'(ind_seq);
				OFF_STAMP:     reg_rdata <= 32'(ind_stamp);
				default:       reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_cap_adv;
		@(posedge mclk) disable iff (!rst_b)
		(anchor_req && reg_wdata[CTRL_ANCHOR_OP]) |-> ##2 bcn_adv.anchor_capable;
	endproperty
	a_cap_adv: assert property (p_cap_adv) // see RULE1
		else $error("anchor capability not advertised");

	property p_elem_needs_hib;
		@(posedge mclk) disable iff (!rst_b)
		$rose(heard_hib) |-> $past(bcn_rx_valid && bcn_rx_hibernation_element) ##1 bcn_adv.anchor_element_on;
	endproperty
	a_elem_needs_hib: assert property (p_elem_needs_hib) // see RULE2
		else $error("anchor element without hibernation element");

	property p_anchor_rx;
		@(posedge mclk) disable iff (!rst_b)
		(bcn_rx_valid && bcn_rx_anchor_element) |=> irq_stat[EV_ANCHOR_RX];
	endproperty
	a_anchor_rx: assert property (p_anchor_rx) // see RULE3
		else $error("anchor reception not flagged");

	property p_anchor_fail;
		@(posedge mclk) disable iff (!rst_b)
		(anchor_req && !reg_wdata[CTRL_ANCHOR_OP] && !anchor_active)
			|=> (res_anchor == OUTCOME_FAILURE) && irq_stat[EV_ANCHOR_CONF];
	endproperty
	a_anchor_fail: assert property (p_anchor_fail) // see RULE4
		else $error("failed anchor stop not reported");

	property p_sleep_conf;
		@(posedge mclk) disable iff (!rst_b)
		sleep_req |=> irq_stat[EV_SLEEP_CONF]
			&& ((res_sleep == OUTCOME_SUCCESS) == (sleep_cfg == $past(sleep_stage)));
	endproperty
	a_sleep_conf: assert property (p_sleep_conf) // see RULE7
		else $error("schedule request outcome wrong");

	property p_unsupported;
		@(posedge mclk) disable iff (!rst_b)
		(sync_req && !group_stage[MCAST_BIT]) |=> (res_sync == OUTCOME_UNSUPPORTED) && !sync_active;
	endproperty
	a_unsupported: assert property (p_unsupported) // see RULE12
		else $error("non-multicast group accepted");

	property p_ind_after_phy;
		@(posedge mclk) disable iff (!rst_b)
		sync_ind |-> $past(phy_done && phy_ok) && irq_stat[EV_SYNC_IND];
	endproperty
	a_ind_after_phy: assert property (p_ind_after_phy) // see RULE13
		else $error("sync indication without physical layer success");

	property p_ind_fields;
		@(posedge mclk) disable iff (!rst_b)
		(match ##1 (!frame_start && !phy_done) [*1] ##1 (phy_done && phy_ok && !frame_start))
			|=> sync_ind && (ind_sender == cap_src) && (ind_stamp == cap_stamp);
	endproperty
	a_ind_fields: assert property (p_ind_fields) // see RULE11
		else $error("sync indication fields lost");

endmodule : mass_support
